// file: mifeb_bank.sv
// Interrupt request flag and enable bank with an Avalon-MM slave and a core request port.
// Assumes one clock; event inputs are one-cycle pulses from logic on that clock,
// the external pins are asynchronous and are synchronised here.
`include "mifeb_cfg.svh"
module mifeb_bank (
  input  wire logic                clock,              // System clock, 25 MHz
  input  wire logic                reset,              // Asynchronous reset, active high
  input  wire logic [5:0]          avs_address,        // Byte address
  input  wire logic                avs_read,           // Read request
  input  wire logic                avs_write,          // Write request
  input  wire logic [31:0]         avs_writedata,      // Write data, low byte used
  input  wire logic [3:0]          avs_byteenable,     // Byte enables, lane 0 used
  output logic [31:0]              avs_readdata,       // Read data
  output logic                     avs_waitrequest,    // Stall while high
  input  wire logic [2:0]          ext_pin,            // External interrupt pins a, b, c
  input  wire logic                comparator_evt,     // Comparator output changed
  input  wire logic                conversion_evt,     // Conversion finished
  input  wire logic                tick0_evt,          // Time base 0 tick
  input  wire logic                tick1_evt,          // Time base 1 tick
  input  wire logic                serial_iface_evt,   // Serial module event
  input  wire logic                uart_a_evt,         // First uart event
  input  wire logic                uart_b_evt,         // Second uart event
  input  wire logic [3:0]          group0_sub_evt,     // ptimer_b A, ptimer_b P, stimer A, stimer P
  input  wire logic [3:0]          group1_sub_evt,     // ctimer A, ctimer P, ptimer_a A, ptimer_a P
  input  wire logic [1:0]          group2_sub_evt,     // nvdata write, supply low
  input  wire logic                irq_ack,            // Core services presented request
  output logic                     irq_req,            // Request to the core
  output mifeb_pkg::mifeb_src_t    irq_src             // Source presented to the core
);
  import mifeb_pkg::*;

  // Register file and its next state
  mifeb_byte_t regs_reg  [`MIFEB_REG_COUNT];
  mifeb_byte_t regs_next [`MIFEB_REG_COUNT];
  mifeb_byte_t set_vec   [`MIFEB_REG_COUNT];
  mifeb_byte_t clr_vec   [`MIFEB_REG_COUNT];

  // Bus slave state
  logic [31:0]  readdata_reg;
  logic [31:0]  readdata_next;
  logic         waitrequest_reg;
  logic         waitrequest_next;
  logic         bus_req;
  logic         bus_take;
  logic         wr_take;
  logic         addr_ok;
  logic [2:0]   addr_idx;

  // Core request state
  logic         irq_req_reg;
  logic         irq_req_next;
  mifeb_src_t   irq_src_reg;
  mifeb_src_t   irq_src_next;
  logic         service;
  logic [MIFEB_SRC_COUNT-1:0] pend;
  logic [8:0]   loc;
  logic [8:0]   ack_loc;
  logic         group0_set;
  logic         group1_set;
  logic         group2_set;

  // Pin synchronisers and edge detection
  logic [2:0]   pin_meta_reg;
  logic [2:0]   pin_sync_reg;
  logic [2:0]   pin_prev_reg;
  logic [2:0]   pin_hit;

  // Implemented bits of each register
  function automatic mifeb_byte_t reg_mask(input logic [2:0] idx);
    case (idx)
      `MIFEB_IDX_EDGE:  reg_mask = `MIFEB_MASK_EDGE;
      `MIFEB_IDX_CTRL0: reg_mask = `MIFEB_MASK_CTRL0;
      `MIFEB_IDX_CTRL3: reg_mask = `MIFEB_MASK_HALF;
      `MIFEB_IDX_SUB2:  reg_mask = `MIFEB_MASK_HALF;
      default:          reg_mask = `MIFEB_MASK_FULL;
    endcase
  endfunction

  // Location of a source: {register index, flag bit, enable bit}
  function automatic logic [8:0] src_loc(input logic [3:0] id);
    case (id)
      MIFEB_SRC_PIN_A:      src_loc = {`MIFEB_IDX_CTRL0, 3'd4, 3'd1};
      MIFEB_SRC_COMPARATOR: src_loc = {`MIFEB_IDX_CTRL0, 3'd5, 3'd2};
      MIFEB_SRC_GROUP0:     src_loc = {`MIFEB_IDX_CTRL0, 3'd6, 3'd3};
      MIFEB_SRC_GROUP1:     src_loc = {`MIFEB_IDX_CTRL1, 3'd4, 3'd0};
      MIFEB_SRC_GROUP2:     src_loc = {`MIFEB_IDX_CTRL1, 3'd5, 3'd1};
      MIFEB_SRC_CONVERSION: src_loc = {`MIFEB_IDX_CTRL1, 3'd6, 3'd2};
      MIFEB_SRC_TICK0:      src_loc = {`MIFEB_IDX_CTRL1, 3'd7, 3'd3};
      MIFEB_SRC_PIN_B:      src_loc = {`MIFEB_IDX_CTRL2, 3'd5, 3'd1};
      MIFEB_SRC_SERIAL:     src_loc = {`MIFEB_IDX_CTRL2, 3'd6, 3'd2};
      MIFEB_SRC_UART_A:     src_loc = {`MIFEB_IDX_CTRL2, 3'd7, 3'd3};
      MIFEB_SRC_TICK1:      src_loc = {`MIFEB_IDX_CTRL2, 3'd4, 3'd0};
      MIFEB_SRC_PIN_C:      src_loc = {`MIFEB_IDX_CTRL3, 3'd5, 3'd1};
      MIFEB_SRC_UART_B:     src_loc = {`MIFEB_IDX_CTRL3, 3'd4, 3'd0};
      default:              src_loc = 9'h000;
    endcase
  endfunction

  // One register step: service clear, then bus write, then hardware set, then mask
  function automatic mifeb_byte_t reg_step(input mifeb_byte_t cur, input logic wr, input mifeb_byte_t wdata,
                                           input mifeb_byte_t clr, input mifeb_byte_t set,
                                           input mifeb_byte_t mask);
    mifeb_byte_t v;
    v = cur & ~clr;
    if (wr) begin
      v = wdata;
    end
    reg_step = (v | set) & mask;
  endfunction

  // Pins pass two flops before edge detection; the first flop feeds only the second
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= ext_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Edge match per pin against its two-bit field
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_edge
      logic [1:0] field;
      logic       rise;
      logic       fall;
      assign field = regs_reg[`MIFEB_IDX_EDGE][2*g+1:2*g];
      assign rise  = pin_sync_reg[g] & ~pin_prev_reg[g];
      assign fall  = ~pin_sync_reg[g] & pin_prev_reg[g];
      assign pin_hit[g] = (field[0] & rise) | (field[1] & fall);

      edge_off_a: assert property (@(posedge clock) disable iff (reset)
        (field == `MIFEB_EDGE_OFF) |-> !pin_hit[g])
        else $error("pin edge detected while its field is off");
    end
  endgenerate

  // Bus decode; a request is taken on the edge where waitrequest is low
  assign bus_req  = avs_read | avs_write;
  assign bus_take = bus_req & ~waitrequest_reg;
  assign addr_ok  = (avs_address[1:0] == 2'b00) && (avs_address[5:2] < 4'(`MIFEB_REG_COUNT));
  assign addr_idx = avs_address[4:2];
  assign wr_take  = avs_write & bus_take & addr_ok & avs_byteenable[0];
  assign service  = irq_ack & irq_req_reg;
  assign ack_loc  = src_loc(irq_src_reg);

  // Next state of the register file, flags and core request
  always_comb begin
    for (int i = 0; i < `MIFEB_REG_COUNT; i++) begin
      set_vec[i] = `MIFEB_RESET_VAL;
      clr_vec[i] = `MIFEB_RESET_VAL;
    end
    // Servicing drops the presented flag and the global enable; sub flags stay
    if (service) begin
      clr_vec[`MIFEB_IDX_CTRL0][`MIFEB_GIE_BIT] = 1'b1;
      clr_vec[ack_loc[8:6]][ack_loc[5:3]] = 1'b1;
    end
    // Sub-source events land in the sub registers first
    set_vec[`MIFEB_IDX_SUB0][7:4] = group0_sub_evt;
    set_vec[`MIFEB_IDX_SUB1][7:4] = group1_sub_evt;
    set_vec[`MIFEB_IDX_SUB2][5:4] = group2_sub_evt;
    for (int i = 5; i < `MIFEB_REG_COUNT; i++) begin
      regs_next[i] = reg_step(regs_reg[i], wr_take && (addr_idx == 3'(i)), avs_writedata[7:0],
                              clr_vec[i], set_vec[i], reg_mask(3'(i)));
    end
    // A group flag sets when any of its sub flags goes from clear to set
    group0_set = |(regs_next[`MIFEB_IDX_SUB0][7:4] & ~regs_reg[`MIFEB_IDX_SUB0][7:4]);
    group1_set = |(regs_next[`MIFEB_IDX_SUB1][7:4] & ~regs_reg[`MIFEB_IDX_SUB1][7:4]);
    group2_set = |(regs_next[`MIFEB_IDX_SUB2][5:4] & ~regs_reg[`MIFEB_IDX_SUB2][5:4]);
    // Primary flags
    set_vec[`MIFEB_IDX_CTRL0][4] = pin_hit[0];
    set_vec[`MIFEB_IDX_CTRL0][5] = comparator_evt;
    set_vec[`MIFEB_IDX_CTRL0][6] = group0_set;
    set_vec[`MIFEB_IDX_CTRL1][4] = group1_set;
    set_vec[`MIFEB_IDX_CTRL1][5] = group2_set;
    set_vec[`MIFEB_IDX_CTRL1][6] = conversion_evt;
    set_vec[`MIFEB_IDX_CTRL1][7] = tick0_evt;
    set_vec[`MIFEB_IDX_CTRL2][4] = tick1_evt;
    set_vec[`MIFEB_IDX_CTRL2][5] = pin_hit[1];
    set_vec[`MIFEB_IDX_CTRL2][6] = serial_iface_evt;
    set_vec[`MIFEB_IDX_CTRL2][7] = uart_a_evt;
    set_vec[`MIFEB_IDX_CTRL3][4] = uart_b_evt;
    set_vec[`MIFEB_IDX_CTRL3][5] = pin_hit[2];
    for (int i = 0; i < 5; i++) begin
      regs_next[i] = reg_step(regs_reg[i], wr_take && (addr_idx == 3'(i)), avs_writedata[7:0],
                              clr_vec[i], set_vec[i], reg_mask(3'(i)));
    end
    // Pending sources, judged on next state so the request never lags a clear
    for (int k = 0; k < MIFEB_SRC_COUNT; k++) begin
      loc = src_loc(4'(k));
      pend[k] = regs_next[loc[8:6]][loc[5:3]] & regs_next[loc[8:6]][loc[2:0]];
    end
    // Fixed priority: the lowest index wins
    irq_src_next = irq_src_reg;
    for (int k = MIFEB_SRC_COUNT - 1; k >= 0; k--) begin
      if (pend[k]) begin
        irq_src_next = mifeb_src_t'(4'(k));
      end
    end
    irq_req_next = regs_next[`MIFEB_IDX_CTRL0][`MIFEB_GIE_BIT] & (|pend);
  end

  // Bus answer: one stall cycle, then waitrequest low for the taking edge
  always_comb begin
    waitrequest_next = ~(bus_req & waitrequest_reg);
    readdata_next    = readdata_reg;
    if (avs_read && waitrequest_reg) begin
      readdata_next = addr_ok ? {24'h00_0000, regs_reg[addr_idx]} : 32'h0000_0000;
    end
  end

  // Registers of the bank
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `MIFEB_REG_COUNT; i++) begin
        regs_reg[i] <= `MIFEB_RESET_VAL;
      end
      readdata_reg    <= 32'h0000_0000;
      waitrequest_reg <= 1'b1;
      irq_req_reg     <= 1'b0;
      irq_src_reg     <= MIFEB_SRC_PIN_A;
    end else begin
      for (int i = 0; i < `MIFEB_REG_COUNT; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      readdata_reg    <= readdata_next;
      waitrequest_reg <= waitrequest_next;
      irq_req_reg     <= irq_req_next;
      irq_src_reg     <= irq_src_next;
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign irq_req         = irq_req_reg;
  assign irq_src         = irq_src_reg;

  // Unimplemented positions never hold ones
  unimpl_zero_a: assert property (@(posedge clock) disable iff (reset)
    (regs_reg[`MIFEB_IDX_EDGE][7:6] == 2'b00) && (regs_reg[`MIFEB_IDX_CTRL0][7] == 1'b0) &&
    (regs_reg[`MIFEB_IDX_CTRL3][3:2] == 2'b00) && (regs_reg[`MIFEB_IDX_SUB2][7:6] == 2'b00))
    else $error("unimplemented bit holds a one");

  // A request is only presented while the global enable is set
  gie_block_a: assert property (@(posedge clock) disable iff (reset)
    irq_req_reg |-> regs_reg[`MIFEB_IDX_CTRL0][`MIFEB_GIE_BIT])
    else $error("request presented with global enable clear");

  // Servicing clears the global enable unless a write lands in the same cycle
  service_gie_a: assert property (@(posedge clock) disable iff (reset)
    (service && !wr_take) |=> !regs_reg[`MIFEB_IDX_CTRL0][`MIFEB_GIE_BIT] && !irq_req_reg)
    else $error("global enable survived servicing");

  // Servicing group 1 leaves its sub flags alone
  sub_keep_a: assert property (@(posedge clock) disable iff (reset)
    (service && !wr_take && regs_reg[`MIFEB_IDX_SUB1][4]) |=> regs_reg[`MIFEB_IDX_SUB1][4])
    else $error("sub flag cleared by servicing");

  // A sub flag rising carries its group flag with it
  group_set_a: assert property (@(posedge clock) disable iff (reset)
    $rose(regs_reg[`MIFEB_IDX_SUB1][6]) |-> regs_reg[`MIFEB_IDX_CTRL1][4])
    else $error("group 1 flag missed a sub flag");

  // A comparator event beats a write of zero in the same cycle
  set_wins_a: assert property (@(posedge clock) disable iff (reset)
    (comparator_evt && wr_take && addr_idx == `MIFEB_IDX_CTRL0 && !avs_writedata[5])
    |=> regs_reg[`MIFEB_IDX_CTRL0][5])
    else $error("comparator event lost to a write");

  // Comparator pending and enabled outranks every source below it
  prio_a: assert property (@(posedge clock) disable iff (reset)
    (irq_req_reg && regs_reg[`MIFEB_IDX_CTRL0][5] && regs_reg[`MIFEB_IDX_CTRL0][2] &&
     !(regs_reg[`MIFEB_IDX_CTRL0][4] && regs_reg[`MIFEB_IDX_CTRL0][1]))
    |-> irq_src_reg == MIFEB_SRC_COMPARATOR)
    else $error("comparator not presented ahead of lower sources");

  // A pin b edge sets its flag at the next edge
  pin_flag_a: assert property (@(posedge clock) disable iff (reset)
    pin_hit[1] |=> regs_reg[`MIFEB_IDX_CTRL2][5])
    else $error("pin b edge did not set its flag");

  // A held request is answered after exactly one stall cycle
  bus_answer_a: assert property (@(posedge clock) disable iff (reset)
    (bus_req && waitrequest_reg) |=> !waitrequest_reg ##1 waitrequest_reg)
    else $error("bus answer not after one stall cycle");

  // The presented source is itself pending and enabled, never a stale index
  req_pending_a: assert property (@(posedge clock) disable iff (reset)
    irq_req_reg |-> regs_reg[ack_loc[8:6]][ack_loc[5:3]] && regs_reg[ack_loc[8:6]][ack_loc[2:0]])
    else $error("presented source not pending and enabled");

  // A write of one to the global enable lands even over a service clear
  gie_write_a: assert property (@(posedge clock) disable iff (reset)
    (wr_take && addr_idx == `MIFEB_IDX_CTRL0 && avs_writedata[0])
    |=> regs_reg[`MIFEB_IDX_CTRL0][`MIFEB_GIE_BIT])
    else $error("global enable write did not land");

  // A pin a edge sets its flag at the next edge
  pin_a_flag_a: assert property (@(posedge clock) disable iff (reset)
    pin_hit[0] |=> regs_reg[`MIFEB_IDX_CTRL0][4])
    else $error("pin a edge did not set its flag");

  // A finished conversion sets its flag at the next edge
  conv_flag_a: assert property (@(posedge clock) disable iff (reset)
    conversion_evt |=> regs_reg[`MIFEB_IDX_CTRL1][6])
    else $error("conversion event did not set its flag");

  // A serial module event sets its flag at the next edge
  serial_flag_a: assert property (@(posedge clock) disable iff (reset)
    serial_iface_evt |=> regs_reg[`MIFEB_IDX_CTRL2][6])
    else $error("serial event did not set its flag");

  // A second uart event sets its flag at the next edge
  uart_b_flag_a: assert property (@(posedge clock) disable iff (reset)
    uart_b_evt |=> regs_reg[`MIFEB_IDX_CTRL3][4])
    else $error("second uart event did not set its flag");

  // Timer match events land in the top nibble of their sub registers
  sub0_match_a: assert property (@(posedge clock) disable iff (reset)
    group0_sub_evt[3] |=> regs_reg[`MIFEB_IDX_SUB0][7])
    else $error("sub register 0 missed a match event");

  sub1_match_a: assert property (@(posedge clock) disable iff (reset)
    group1_sub_evt[0] |=> regs_reg[`MIFEB_IDX_SUB1][4])
    else $error("sub register 1 missed a match event");

  // A data store event sets its sub flag at the next edge
  nvdata_flag_a: assert property (@(posedge clock) disable iff (reset)
    group2_sub_evt[1] |=> regs_reg[`MIFEB_IDX_SUB2][5])
    else $error("data store event did not set its flag");
endmodule // mifeb_bank

// file: mifeb_cfg.svh
// Constants of the interrupt flag and enable bank: offsets, masks, field positions.
// Assumes inclusion by the bank's package, module and bench; definitions only.
//
// Contract
// - Two-bit edge code: off, rise, fall, both
// - Edge fields: pin c 5:4, b 3:2, a 1:0
// - Unimplemented bits ignore writes, read zero
// - Control 0 bit 0 is global enable
// - Control 0: pin a flag 4, enable 1
// - Control 0: comparator flag 5, enable 2
// - Group 0 in control 0; groups 1,2 control 1
// - Control 1: tick0 flag 7, conversion flag 6
// - Control 2: uart a, serial, pin b, tick1
// - Control 3: pin c flag 5, uart b 4
// - Flag one means pending; enable one permits (sub register enables gate nothing: any sub flag raises its group flag)
// - Sub register 0: four timer match flags, enables
// - Sub register 1: four timer match flags, enables
// - Sub register 2: nvdata flag 5, supply low 4
// - Group flag sets when any sub flag sets
// - Global enable zero blocks every interrupt request
// - Servicing clears source flag and global enable
// - Pin flag sets on the selected edge
`ifndef MIFEB_CFG_SVH
`define MIFEB_CFG_SVH

// Byte offsets on the register bus
`define MIFEB_OFS_EDGE     6'h00
`define MIFEB_OFS_CTRL0    6'h04
`define MIFEB_OFS_CTRL1    6'h08
`define MIFEB_OFS_CTRL2    6'h0C
`define MIFEB_OFS_CTRL3    6'h10
`define MIFEB_OFS_SUB0     6'h14
`define MIFEB_OFS_SUB1     6'h18
`define MIFEB_OFS_SUB2     6'h1C
`define MIFEB_REG_COUNT    8

// Register indices
`define MIFEB_IDX_EDGE     3'd0
`define MIFEB_IDX_CTRL0    3'd1
`define MIFEB_IDX_CTRL1    3'd2
`define MIFEB_IDX_CTRL2    3'd3
`define MIFEB_IDX_CTRL3    3'd4
`define MIFEB_IDX_SUB0     3'd5
`define MIFEB_IDX_SUB1     3'd6
`define MIFEB_IDX_SUB2     3'd7

// Implemented bit masks and reset value
`define MIFEB_MASK_EDGE    8'h3F
`define MIFEB_MASK_CTRL0   8'h7F
`define MIFEB_MASK_FULL    8'hFF
`define MIFEB_MASK_HALF    8'h33
`define MIFEB_RESET_VAL    8'h00

// Field positions
`define MIFEB_GIE_BIT      3'd0
`define MIFEB_EDGE_RISE    2'b01
`define MIFEB_EDGE_FALL    2'b10
`define MIFEB_EDGE_BOTH    2'b11
`define MIFEB_EDGE_OFF     2'b00

`endif

// file: mifeb_pkg.sv
// Types of the interrupt flag and enable bank.
// Assumes mifeb_cfg.svh sits in the include path.
package mifeb_pkg;
  `include "mifeb_cfg.svh"

  typedef logic [7:0] mifeb_byte_t;

  // Sources in fixed priority order, highest first
  typedef enum logic [3:0] {
    MIFEB_SRC_PIN_A,
    MIFEB_SRC_COMPARATOR,
    MIFEB_SRC_GROUP0,
    MIFEB_SRC_GROUP1,
    MIFEB_SRC_GROUP2,
    MIFEB_SRC_CONVERSION,
    MIFEB_SRC_TICK0,
    MIFEB_SRC_PIN_B,
    MIFEB_SRC_SERIAL,
    MIFEB_SRC_UART_A,
    MIFEB_SRC_TICK1,
    MIFEB_SRC_PIN_C,
    MIFEB_SRC_UART_B
  } mifeb_src_t;

  localparam int MIFEB_SRC_COUNT = 13;
endpackage

// file: mifeb_core_model.sv
// Core-side partner of the interrupt bank: services the presented request after a stall.
// Assumes the bank's clock and reset; irq_ack is a one-cycle pulse given only while irq_req is high.
module mifeb_core_model (
  input  wire logic                  clock,     // System clock
  input  wire logic                  reset,     // Asynchronous reset, active high
  input  wire logic                  irq_req,   // Request from the bank
  input  wire mifeb_pkg::mifeb_src_t irq_src,   // Source presented by the bank
  input  wire logic                  ack_on,    // Bench lets the core take requests
  input  wire logic [3:0]            ack_wait,  // Stall cycles before servicing
  output logic                       irq_ack,   // Service pulse
  output mifeb_pkg::mifeb_src_t      last_src   // Source taken at the last service
);
  timeunit 1ns;
  timeprecision 1ps;
  import mifeb_pkg::*;

  logic [3:0] wait_reg;

  // Stall counter; a slow core lets other requests pile up behind the pending one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_reg <= 4'h0;
      irq_ack  <= 1'b0;
      last_src <= MIFEB_SRC_PIN_A;
    end else if (irq_ack) begin
      irq_ack  <= 1'b0;          // One pulse per request, never a held level
      wait_reg <= 4'h0;
    end else if (ack_on && irq_req && wait_reg >= ack_wait) begin
      irq_ack  <= 1'b1;
      last_src <= irq_src;
    end else if (ack_on && irq_req) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      wait_reg <= 4'h0;
    end
  end
endmodule // mifeb_core_model

// file: mifeb_bank_bench.sv
// Self-checking bench of the interrupt bank: Avalon-MM tasks, event pulses, core partner.
// Assumes mifeb_cfg.svh in the include path and the bank's one-stall-cycle bus answer.
`include "mifeb_cfg.svh"
module mifeb_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mifeb_pkg::*;

  logic clock = 0, reset = 1, avs_read = 0, avs_write = 0, irq_ack, irq_req, ack_on = 0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  ext_pin = 3'h0;
  logic [6:0]  evt = 7'h00;
  logic [3:0]  g0 = 4'h0, g1 = 4'h0;
  logic [1:0]  g2 = 2'h0;
  logic [7:0]  rd;
  mifeb_src_t  irq_src, last_src;
  int fails = 0, comparisons = 0, cycles = 0;

  mifeb_bank u_dut (.clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_pin(ext_pin),
    .comparator_evt(evt[0]), .conversion_evt(evt[1]), .tick0_evt(evt[2]), .tick1_evt(evt[3]),
    .serial_iface_evt(evt[4]), .uart_a_evt(evt[5]), .uart_b_evt(evt[6]), .group0_sub_evt(g0),
    .group1_sub_evt(g1), .group2_sub_evt(g2), .irq_ack(irq_ack), .irq_req(irq_req), .irq_src(irq_src));
  mifeb_core_model u_core (.clock(clock), .reset(reset), .irq_req(irq_req), .irq_src(irq_src),
    .ack_on(ack_on), .ack_wait(4'h3), .irq_ack(irq_ack), .last_src(last_src));

  // Clock and a cycle ceiling well above the several hundred cycles the tests need
  initial forever #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // One Avalon access; the request is held until the edge that samples waitrequest low
  // No local limit: only the cycle ceiling ends a wait that never gets its answer
  task automatic bus_op(input logic wr, input logic [5:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);        // Keeps strobes from being set twice in one time step
  endtask

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
    bus_op(1'b0, a, 8'h00);
    check8(what, exp, rd);
  endtask

  task automatic serviced();
    int n;
    n = 0;
    while (irq_req !== 1'b0 && n < 64) begin
      @(posedge clock);
      n++;
    end
    if (n >= 64) begin
      fails++;
      complete_run();
    end
    @(posedge clock);
  endtask

  logic [5:0] ofs [8] = '{`MIFEB_OFS_EDGE, `MIFEB_OFS_CTRL0, `MIFEB_OFS_CTRL1, `MIFEB_OFS_CTRL2,
                          `MIFEB_OFS_CTRL3, `MIFEB_OFS_SUB0, `MIFEB_OFS_SUB1, `MIFEB_OFS_SUB2};
  logic [7:0] msk [8] = '{8'h3F, 8'h7F, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};
  int pin_reg [3] = '{1, 3, 4};
  int pin_bit [3] = '{4, 5, 5};
  int evt_reg [7] = '{1, 2, 2, 3, 3, 3, 4};
  int evt_bit [7] = '{5, 6, 7, 4, 6, 7, 4};
  int grp_reg [3] = '{1, 2, 2};
  int grp_bit [3] = '{6, 4, 5};

  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // Reset values, implemented bits, unmapped space
    for (int i = 0; i < 8; i++) rd_chk("reset value", ofs[i], 8'h00);
    for (int i = 0; i < 8; i++) bus_op(1'b1, ofs[i], 8'hFF);
    for (int i = 0; i < 8; i++) rd_chk("writable bits", ofs[i], msk[i]);
    rd_chk("unmapped", 6'h20, 8'h00);
    for (int i = 0; i < 8; i++) bus_op(1'b1, ofs[i], 8'h00);
    $display("test registers done");
    // Every edge code on every pin, both pin directions
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        bus_op(1'b1, ofs[0], 8'(c << (2 * p)));
        ext_pin[p] <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk("rise flag", ofs[pin_reg[p]], 8'(c[0]) << pin_bit[p]);
        bus_op(1'b1, ofs[pin_reg[p]], 8'h00);
        ext_pin[p] <= 1'b0;
        repeat (4) @(posedge clock);
        rd_chk("fall flag", ofs[pin_reg[p]], 8'(c[1]) << pin_bit[p]);
        bus_op(1'b1, ofs[pin_reg[p]], 8'h00);
      end
    end
    bus_op(1'b1, ofs[0], 8'h00);
    $display("test pins done");
    // Single-source events land on their own flag bit
    for (int i = 0; i < 7; i++) begin
      evt[i] <= 1'b1;
      @(posedge clock);
      evt[i] <= 1'b0;
      rd_chk("event flag", ofs[evt_reg[i]], 8'h01 << evt_bit[i]);
      bus_op(1'b1, ofs[evt_reg[i]], 8'h00);
    end
    $display("test events done");
    // Sub-source events and the group flag they raise
    for (int g = 0; g < 3; g++) begin
      for (int b = 0; b < ((g == 2) ? 2 : 4); b++) begin
        if (g == 0) g0[b] <= 1'b1;
        else if (g == 1) g1[b] <= 1'b1;
        else g2[b] <= 1'b1;
        @(posedge clock);
        g0 <= 4'h0;
        g1 <= 4'h0;
        g2 <= 2'h0;
        rd_chk("sub flag", ofs[5 + g], 8'h10 << b);
        rd_chk("group flag", ofs[grp_reg[g]], 8'h01 << grp_bit[g]);
        bus_op(1'b1, ofs[5 + g], 8'h00);
        bus_op(1'b1, ofs[grp_reg[g]], 8'h00);
      end
    end
    $display("test groups done");
    // Global enable, priority, service
    bus_op(1'b1, ofs[4], 8'h03);
    bus_op(1'b1, ofs[1], 8'h04);
    evt[0] <= 1'b1;
    evt[6] <= 1'b1;
    @(posedge clock);
    evt <= 7'h00;
    repeat (2) @(posedge clock);
    check8("masked request", 8'h00, {7'h00, irq_req});
    bus_op(1'b1, ofs[1], 8'h25);
    check8("request", 8'h01, {7'h00, irq_req});
    check8("presented source", {4'h0, MIFEB_SRC_COMPARATOR}, {4'h0, irq_src});
    ack_on <= 1'b1;
    serviced();
    check8("serviced source", {4'h0, MIFEB_SRC_COMPARATOR}, {4'h0, last_src});
    rd_chk("ctrl0 after service", ofs[1], 8'h04);
    rd_chk("ctrl3 still pending", ofs[4], 8'h13);
    bus_op(1'b1, ofs[1], 8'h05);
    serviced();
    check8("serviced source", {4'h0, MIFEB_SRC_UART_B}, {4'h0, last_src});
    rd_chk("ctrl3 after service", ofs[4], 8'h03);
    bus_op(1'b1, ofs[2], 8'h01);
    g1[0] <= 1'b1;
    @(posedge clock);
    g1 <= 4'h0;
    bus_op(1'b1, ofs[1], 8'h01);
    serviced();
    rd_chk("group1 cleared", ofs[2], 8'h01);
    rd_chk("sub flag kept", ofs[6], 8'h10);
    ack_on <= 1'b0;
    $display("test service done");
    // Event in the cycle a write of zero lands
    evt[0] <= 1'b1;
    @(posedge clock);
    evt[0] <= 1'b0;
    fork
      bus_op(1'b1, ofs[1], 8'h00);
      begin
        wait (avs_write === 1'b1 && avs_waitrequest === 1'b0);
        evt[0] <= 1'b1;
        @(posedge clock);
        evt[0] <= 1'b0;
      end
    join
    rd_chk("set beats clear", ofs[1], 8'h20);
    $display("test collision done");
    complete_run();
  end
endmodule // mifeb_bank_bench
